// *** logic/pwmleb_consts.svh ***
// Offsets, field positions and reset values of the blanking block
`ifndef PWMLEB_CONSTS_SVH
`define PWMLEB_CONSTS_SVH

// ****************************************************************
// Register offsets
// ****************************************************************
`define PWMLEB_OFS_CONTROL 4'h0
`define PWMLEB_OFS_DELAY 4'h1
`define PWMLEB_OFS_AUX 4'h2
`define PWMLEB_OFS_STATUS 4'h3

// ****************************************************************
// Control register fields and register reset values
// ****************************************************************
`define PWMLEB_BIT_HR 15
`define PWMLEB_BIT_HF 14
`define PWMLEB_BIT_LR 13
`define PWMLEB_BIT_LF 12
`define PWMLEB_BIT_FLT 11
`define PWMLEB_BIT_CL 10
`define PWMLEB_BIT_SH 5
`define PWMLEB_BIT_SL 4
`define PWMLEB_BIT_HH 3
`define PWMLEB_BIT_HL 2
`define PWMLEB_BIT_LH 1
`define PWMLEB_BIT_LL 0
`define PWMLEB_CTRL_MASK 16'hFC3F
`define PWMLEB_CTRL_RESET 16'h0000
`define PWMLEB_DELAY_RESET 12'h000
`define PWMLEB_AUX_RESET 2'h0

`endif

// *** logic/pwmleb_pkg.sv ***
// Types shared by the blanking block
package pwmleb_pkg;
    typedef logic [15:0] pwmleb_word_t;
    typedef enum logic {PWMLEB_IDLE, PWMLEB_BLANK} pwmleb_state_e;
endpackage

// *** logic/pwmleb_top.sv ***
// Leading-edge and state blanking for one PWM channel
//
// The register offsets and the address-and-strobe port were chosen for this implementation.
`timescale 1ns/1ps
`include "pwmleb_consts.svh"

// Notes on behaviour
// - With high-rise trigger enabled, each rising edge of the high-side output restarts the blanking counter.
// - With high-fall trigger enabled, each falling edge of the high-side output restarts the blanking counter.
// - With low-rise trigger enabled, each rising edge of the low-side output restarts the blanking counter.
// - With low-fall trigger enabled, each falling edge of the low-side output restarts the blanking counter.
// - Fault blank enable lets leading-edge blanking mask the fault input while the counter runs.
// - Current-limit blank enable lets leading-edge blanking mask the current-limit input.
// - Control bits nine to six do not exist and read as zero.
// - Selected-signal-high enable blanks both inputs while the selected blanking signal is high.
// - Selected-signal-low enable blanks both inputs while the selected blanking signal is low.
// - High-out-high enable blanks both inputs while the high-side output is high.
// - High-out-low enable blanks both inputs while the high-side output is low.
// - Low-out-high enable blanks both inputs while the low-side output is high.
// - Low-out-low enable blanks both inputs while the low-side output is low.
// - The leading-edge interval length is a 12-bit delay value in its own register.
// - The external blanking signal is picked by a source select field in an auxiliary register.
module pwmleb_top
    import pwmleb_pkg::*;
#(
    parameter int DELAY_W = 12,
    parameter int NSRC = 4
) (
    input wire logic CLK_IN, // 250 MHz clock
    input wire logic RESET_N_IN, // Synchronous reset, active low
    input wire logic CLK_EN_IN, // Freezes all state when low
    input wire logic [3:0] ADDR_IN, // Register address
    input wire logic [15:0] WDATA_IN, // Write data
    input wire logic WR_IN, // Write strobe
    input wire logic RD_IN, // Read strobe
    input wire logic HIGH_SIDE_OUTPUT_IN, // High-side PWM output level
    input wire logic LOW_SIDE_OUTPUT_IN, // Low-side PWM output level
    input wire logic [NSRC-1:0] BLANK_SRC_IN, // Candidate external blanking signals
    input wire logic FAULT_IN, // Raw fault input, active high
    input wire logic CURRENT_LIMIT_IN, // Raw current-limit input, active high
    output logic [15:0] RDATA_OUT, // Read data, cycle after read strobe
    output logic FAULT_OUT, // Fault after blanking
    output logic CURRENT_LIMIT_OUT, // Current limit after blanking
    output logic BLANKING_OUT // Any blanking active
);

    localparam int SEL_W = (NSRC > 1) ? $clog2(NSRC) : 1;

    // Refuse shapes the register map cannot hold
    if (DELAY_W < 1 || DELAY_W > 12) begin
        $error("DELAY_W must be 1 to 12");
    end
    if (NSRC < 1 || NSRC > 4) begin
        $error("NSRC must be 1 to 4");
    end

    // ****************************************************************
    // Pin synchronisers
    // ****************************************************************
    logic hs_ff, nxt_hs, ls_ff, nxt_ls, fl_ff, cl_ff;
    logic [NSRC-1:0] src_ff;

    // High-side output level, next value feeds the edge detector
    pwmleb_pin_sync #(.WIDTH(1)) u_pwmleb_pin_sync_hs (
        .clk_in(CLK_IN),
        .reset_n_in(RESET_N_IN),
        .clk_en_in(CLK_EN_IN),
        .pin_in(HIGH_SIDE_OUTPUT_IN),
        .level_out(hs_ff),
        .nxt_level_out(nxt_hs)
    );

    // Low-side output level, next value feeds the edge detector
    pwmleb_pin_sync #(.WIDTH(1)) u_pwmleb_pin_sync_ls (
        .clk_in(CLK_IN),
        .reset_n_in(RESET_N_IN),
        .clk_en_in(CLK_EN_IN),
        .pin_in(LOW_SIDE_OUTPUT_IN),
        .level_out(ls_ff),
        .nxt_level_out(nxt_ls)
    );

    // Raw fault input
    pwmleb_pin_sync #(.WIDTH(1)) u_pwmleb_pin_sync_fl (
        .clk_in(CLK_IN),
        .reset_n_in(RESET_N_IN),
        .clk_en_in(CLK_EN_IN),
        .pin_in(FAULT_IN),
        .level_out(fl_ff),
        .nxt_level_out()
    );

    // Raw current-limit input
    pwmleb_pin_sync #(.WIDTH(1)) u_pwmleb_pin_sync_cl (
        .clk_in(CLK_IN),
        .reset_n_in(RESET_N_IN),
        .clk_en_in(CLK_EN_IN),
        .pin_in(CURRENT_LIMIT_IN),
        .level_out(cl_ff),
        .nxt_level_out()
    );

    // Candidate external blanking signals
    pwmleb_pin_sync #(.WIDTH(NSRC)) u_pwmleb_pin_sync_src (
        .clk_in(CLK_IN),
        .reset_n_in(RESET_N_IN),
        .clk_en_in(CLK_EN_IN),
        .pin_in(BLANK_SRC_IN),
        .level_out(src_ff),
        .nxt_level_out()
    );

    // ****************************************************************
    // Registers
    // ****************************************************************
    pwmleb_word_t ctrl_ff, nxt_ctrl;
    logic [DELAY_W-1:0] delay_ff, nxt_delay;
    logic [1:0] aux_ff, nxt_aux;
    pwmleb_word_t rdata_ff, nxt_rdata;
    logic [DELAY_W-1:0] cnt_ff, nxt_cnt;
    pwmleb_state_e state_ff, nxt_state;
    logic fault_out_ff, cl_out_ff, blank_out_ff;
    logic nxt_fault_out, nxt_cl_out, nxt_blank_out;

    // Register writes and read mux
    always_comb begin
        nxt_ctrl = ctrl_ff;
        nxt_delay = delay_ff;
        nxt_aux = aux_ff;
        nxt_rdata = 16'h0000;
        if (WR_IN) begin
            case (ADDR_IN)
                `PWMLEB_OFS_CONTROL: nxt_ctrl = WDATA_IN & `PWMLEB_CTRL_MASK;
                `PWMLEB_OFS_DELAY: nxt_delay = WDATA_IN[DELAY_W-1:0];
                `PWMLEB_OFS_AUX: nxt_aux = WDATA_IN[1:0];
                default: ;
            endcase
        end
        if (RD_IN) begin
            case (ADDR_IN)
                `PWMLEB_OFS_CONTROL: nxt_rdata = ctrl_ff;
                `PWMLEB_OFS_DELAY: nxt_rdata = 16'(delay_ff);
                `PWMLEB_OFS_AUX: nxt_rdata = {14'h0000, aux_ff};
                `PWMLEB_OFS_STATUS: nxt_rdata = {4'h0, 12'(cnt_ff)};
                default: nxt_rdata = 16'h0000;
            endcase
        end
    end

    // ****************************************************************
    // Blanking logic
    // ****************************************************************
    logic trig, sel_sig, state_blank, leb_active;
    logic [SEL_W-1:0] sel_idx;

    // Trigger edges, state blanking and counter
    always_comb begin
        trig = 1'b0;
        if (ctrl_ff[`PWMLEB_BIT_HR] && nxt_hs && !hs_ff) trig = 1'b1;
        if (ctrl_ff[`PWMLEB_BIT_HF] && !nxt_hs && hs_ff) trig = 1'b1;
        if (ctrl_ff[`PWMLEB_BIT_LR] && nxt_ls && !ls_ff) trig = 1'b1;
        if (ctrl_ff[`PWMLEB_BIT_LF] && !nxt_ls && ls_ff) trig = 1'b1;
        sel_idx = SEL_W'(aux_ff);
        sel_sig = (int'(sel_idx) < NSRC) ? src_ff[sel_idx] : 1'b0;
        state_blank = (ctrl_ff[`PWMLEB_BIT_SH] && sel_sig)
            || (ctrl_ff[`PWMLEB_BIT_SL] && !sel_sig)
            || (ctrl_ff[`PWMLEB_BIT_HH] && hs_ff)
            || (ctrl_ff[`PWMLEB_BIT_HL] && !hs_ff)
            || (ctrl_ff[`PWMLEB_BIT_LH] && ls_ff)
            || (ctrl_ff[`PWMLEB_BIT_LL] && !ls_ff);
        nxt_cnt = cnt_ff;
        nxt_state = state_ff;
        case (state_ff)
            PWMLEB_IDLE: begin
                if (trig && delay_ff != '0) begin
                    nxt_cnt = delay_ff;
                    nxt_state = PWMLEB_BLANK;
                end
            end
            PWMLEB_BLANK: begin
                if (trig) begin
                    nxt_cnt = delay_ff;
                    if (delay_ff == '0) nxt_state = PWMLEB_IDLE;
                end else if (cnt_ff <= DELAY_W'(1)) begin
                    nxt_cnt = '0;
                    nxt_state = PWMLEB_IDLE;
                end else begin
                    nxt_cnt = cnt_ff - DELAY_W'(1);
                end
            end
            default: begin
                nxt_cnt = '0;
                nxt_state = PWMLEB_IDLE;
            end
        endcase
    end

    // Mask the inputs and report blanking
    always_comb begin
        leb_active = (state_ff == PWMLEB_BLANK);
        nxt_fault_out = fl_ff && !((leb_active && ctrl_ff[`PWMLEB_BIT_FLT]) || state_blank);
        nxt_cl_out = cl_ff && !((leb_active && ctrl_ff[`PWMLEB_BIT_CL]) || state_blank);
        nxt_blank_out = leb_active || state_blank;
    end

    // Register the software-visible registers and read data
    always_ff @(posedge CLK_IN) begin
        if (!RESET_N_IN) begin
            ctrl_ff <= `PWMLEB_CTRL_RESET;
            delay_ff <= DELAY_W'(`PWMLEB_DELAY_RESET);
            aux_ff <= `PWMLEB_AUX_RESET;
            rdata_ff <= 16'h0000;
        end else if (CLK_EN_IN) begin
            ctrl_ff <= nxt_ctrl;
            delay_ff <= nxt_delay;
            aux_ff <= nxt_aux;
            rdata_ff <= nxt_rdata;
        end
    end

    // Register the blanking counter and its state
    always_ff @(posedge CLK_IN) begin
        if (!RESET_N_IN) begin
            cnt_ff <= '0;
            state_ff <= PWMLEB_IDLE;
        end else if (CLK_EN_IN) begin
            cnt_ff <= nxt_cnt;
            state_ff <= nxt_state;
        end
    end

    // Register the masked inputs and the blanking flag
    always_ff @(posedge CLK_IN) begin
        if (!RESET_N_IN) begin
            fault_out_ff <= 1'b0;
            cl_out_ff <= 1'b0;
            blank_out_ff <= 1'b0;
        end else if (CLK_EN_IN) begin
            fault_out_ff <= nxt_fault_out;
            cl_out_ff <= nxt_cl_out;
            blank_out_ff <= nxt_blank_out;
        end
    end

    // Outputs straight from flip-flops
    assign RDATA_OUT = rdata_ff;
    assign FAULT_OUT = fault_out_ff;
    assign CURRENT_LIMIT_OUT = cl_out_ff;
    assign BLANKING_OUT = blank_out_ff;

endmodule

// ****************************************************************
// Pin synchroniser
// ****************************************************************
// Three stage flip-flops and one level flip-flop per pin; a level counts once stages two and three agree
module pwmleb_pin_sync
    import pwmleb_pkg::*;
#(
    parameter int WIDTH = 1
) (
    input wire logic clk_in, // Block clock
    input wire logic reset_n_in, // Synchronous reset, active low
    input wire logic clk_en_in, // Freezes the stages when low
    input wire logic [WIDTH-1:0] pin_in, // Raw pin levels
    output logic [WIDTH-1:0] level_out, // Accepted levels
    output logic [WIDTH-1:0] nxt_level_out // Levels accepted at the next edge
);

    // Refuse an empty group
    if (WIDTH < 1) begin
        $error("WIDTH must be at least 1");
    end

    logic [2:0] stage_ff [WIDTH];
    logic [2:0] nxt_stage [WIDTH];
    logic [WIDTH-1:0] level_ff, nxt_level;

    // Shift pins in; a single-stage glitch never reaches the level
    always_comb begin
        for (int i = 0; i < WIDTH; i++) begin
            nxt_stage[i] = {stage_ff[i][1:0], pin_in[i]};
            nxt_level[i] = (stage_ff[i][1] == stage_ff[i][2]) ? stage_ff[i][2] : level_ff[i];
        end
    end

    // Register the stages and the accepted levels
    always_ff @(posedge clk_in) begin
        if (!reset_n_in) begin
            level_ff <= '0;
            for (int i = 0; i < WIDTH; i++) begin
                stage_ff[i] <= 3'h0;
            end
        end else if (clk_en_in) begin
            level_ff <= nxt_level;
            for (int i = 0; i < WIDTH; i++) begin
                stage_ff[i] <= nxt_stage[i];
            end
        end
    end

    // Accepted levels and the values they take at the next edge
    assign level_out = level_ff;
    assign nxt_level_out = nxt_level;

endmodule

// *** verification/pwm_leading_edge_blanking_bench.sv ***
// Register and blanking tests
`timescale 1ns/1ps
`include "pwmleb_consts.svh"
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin n_errors++; \
    $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e); end end
module pwm_leading_edge_blanking_bench;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [3:0] addr = 4'h0;
    logic [15:0] wdata = 16'h0000;
    logic hs, ls, flt, cl, fault_o, cl_o, blank_o, lvl;
    logic [3:0] src;
    logic [15:0] rdata_o, t, mask;
    logic [15:0] en_tab [4] = '{16'h0C00, 16'h0800, 16'h0400, 16'h0C00};
    int n_errors = 0;
    int comparisons = 0;
    int i, j, b, fc, cc;
    // Clock
    initial forever #2 clk = ~clk;
    pwmleb_top #(.DELAY_W(12), .NSRC(4)) u_pwmleb_top (.CLK_IN(clk), .RESET_N_IN(rst_n), .CLK_EN_IN(1'b1),
        .ADDR_IN(addr), .WDATA_IN(wdata), .WR_IN(wr), .RD_IN(rd), .HIGH_SIDE_OUTPUT_IN(hs),
        .LOW_SIDE_OUTPUT_IN(ls), .BLANK_SRC_IN(src), .FAULT_IN(flt), .CURRENT_LIMIT_IN(cl),
        .RDATA_OUT(rdata_o), .FAULT_OUT(fault_o), .CURRENT_LIMIT_OUT(cl_o), .BLANKING_OUT(blank_o));
    pwmleb_stage_model u_pwmleb_stage_model (.clk_in(clk), .hs_out(hs), .ls_out(ls), .src_out(src),
        .flt_out(flt), .cl_out(cl));
    task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    // Read data is taken in the cycle after the strobe
    task automatic rd_chk(input logic [3:0] a, input logic [15:0] e);
        @(posedge clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        `CHK(rdata_o, e)
    endtask
    task automatic settle(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic set_pins(input logic h, input logic l, input logic [3:0] s);
        u_pwmleb_stage_model.drive({s, l, h, 2'b11});
    endtask
    task automatic results;
        if (n_errors == 0 && comparisons > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    // Watchdog
    initial begin
        #100000;
        n_errors++;
        results();
    end
    initial begin
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        rd_chk(4'h0, `PWMLEB_CTRL_RESET);
        rd_chk(4'h1, 16'h0000);
        rd_chk(4'h2, 16'h0000);
        wr_reg(4'h3, 16'hFFFF);
        rd_chk(4'h3, 16'h0000);
        wr_reg(4'h0, 16'hFFFF);
        wr_reg(4'h9, 16'h0000);
        rd_chk(4'h0, `PWMLEB_CTRL_MASK);
        rd_chk(4'h9, 16'h0000);
        wr_reg(4'h1, 16'hFFFF);
        rd_chk(4'h1, 16'h0FFF);
        wr_reg(4'h2, 16'hFFFF);
        rd_chk(4'h2, 16'h0003);
        wr_reg(4'h1, 16'h0006);
        wr_reg(4'h2, 16'h0002);
        // State blanking, one enable at a time; source 2 selected, others opposite
        for (i = 0; i < 6; i++) begin
            wr_reg(4'h0, 16'h0001 << i);
            for (j = 0; j < 2; j++) begin
                lvl = ~(i[0] ^ j[0]);
                set_pins(lvl, lvl, {~lvl, lvl, ~lvl, ~lvl});
                settle(32);
                `CHK(blank_o, j[0])
                `CHK(fault_o, ~j[0])
                `CHK(cl_o, ~j[0])
            end
        end
        // Each trigger edge with each mask choice, and with its own trigger off
        for (i = 0; i < 16; i++) begin
            b = 15 - i / 4;
            t = 16'h0001 << b;
            mask = (i % 4 == 3) ? (16'hF000 & ~t) : t;
            wr_reg(4'h0, 16'h0000);
            set_pins((b >= 14) ? ~b[0] : 1'b0, (b < 14) ? ~b[0] : 1'b0, 4'h0);
            settle(8);
            wr_reg(4'h0, mask | en_tab[i % 4]);
            settle(32);
            set_pins((b >= 14) ? b[0] : 1'b0, (b < 14) ? b[0] : 1'b0, 4'h0);
            fc = 0;
            cc = 0;
            repeat (20) begin
                settle(1);
                fc += (fault_o === 1'b0);
                cc += (cl_o === 1'b0);
            end
            `CHK(fc, ((mask & t) != 0 && en_tab[i % 4][11]) ? 6 : 0)
            `CHK(cc, ((mask & t) != 0 && en_tab[i % 4][10]) ? 6 : 0)
            `CHK(fault_o, 1'b1)
            `CHK(cl_o, 1'b1)
        end
        results();
    end
endmodule

// *** verification/pwmleb_props.sv ***
// Checker for the blanking block ports
`timescale 1ns/1ps
module pwmleb_checker #(parameter int DELAY_W = 12, parameter int NSRC = 4) (
    input wire logic CLK_IN, // Clock
    input wire logic RESET_N_IN, // Reset
    input wire logic CLK_EN_IN, // Enable
    input wire logic [3:0] ADDR_IN, // Address
    input wire logic [15:0] WDATA_IN, // Write data
    input wire logic WR_IN, // Write
    input wire logic RD_IN, // Read
    input wire logic HIGH_SIDE_OUTPUT_IN, // High side
    input wire logic LOW_SIDE_OUTPUT_IN, // Low side
    input wire logic [NSRC-1:0] BLANK_SRC_IN, // Sources
    input wire logic FAULT_IN, // Raw fault
    input wire logic CURRENT_LIMIT_IN, // Raw limit
    input wire logic [15:0] RDATA_OUT, // Read data
    input wire logic FAULT_OUT, // Fault
    input wire logic CURRENT_LIMIT_OUT, // Limit
    input wire logic BLANKING_OUT // Blanking
);
    logic [15:0] ctrl_ff;
    logic [11:0] dly_ff;
    logic [4:0] calm_ff;
    logic [4:0] run_ff;
    logic [7:0] flt_ff;
    // Shadow registers; calm counts cycles since a control write
    always_ff @(posedge CLK_IN) begin
        if (!RESET_N_IN) begin
            ctrl_ff <= 16'h0000;
            dly_ff <= 12'h000;
            calm_ff <= 5'h00;
            run_ff <= 5'h00;
            flt_ff <= 8'h00;
        end else if (CLK_EN_IN) begin
            if (WR_IN && ADDR_IN == 4'h0) ctrl_ff <= WDATA_IN & 16'hFC3F;
            if (WR_IN && ADDR_IN == 4'h1) dly_ff <= WDATA_IN[11:0];
            calm_ff <= (WR_IN && ADDR_IN == 4'h0) ? 5'h00 : ((calm_ff == 5'h1F) ? 5'h1F : calm_ff + 5'h01);
            run_ff <= !BLANKING_OUT ? 5'h00 : ((run_ff == 5'h1F) ? 5'h1F : run_ff + 5'h01);
            flt_ff <= {flt_ff[6:0], FAULT_IN};
        end
    end
    default clocking cb @(posedge CLK_IN); endclocking
    default disable iff (!RESET_N_IN);
    property p_ctrl_rd; RD_IN && ADDR_IN == 4'h0 |=> RDATA_OUT == ctrl_ff; endproperty
    a_ctrl_rd: assert property (p_ctrl_rd) else $error("control readback wrong");
    property p_dly_rd; RD_IN && ADDR_IN == 4'h1 |=> RDATA_OUT == {4'h0, dly_ff}; endproperty
    a_dly_rd: assert property (p_dly_rd) else $error("delay readback wrong");
    property p_aux_rd; RD_IN && ADDR_IN == 4'h2 |=> RDATA_OUT[15:2] == 14'h0000; endproperty
    a_aux_rd: assert property (p_aux_rd) else $error("aux upper bits set");
    property p_unmapped; RD_IN && ADDR_IN > 4'h3 |=> RDATA_OUT == 16'h0000; endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
    property p_flt_mask; FAULT_OUT && ctrl_ff[11] && calm_ff == 5'h1F |-> !BLANKING_OUT; endproperty
    a_flt_mask: assert property (p_flt_mask) else $error("fault passed while blanked");
    property p_cl_mask; CURRENT_LIMIT_OUT && ctrl_ff[10] && calm_ff == 5'h1F |-> !BLANKING_OUT; endproperty
    a_cl_mask: assert property (p_cl_mask) else $error("limit passed while blanked");
    property p_state_mask;
        BLANKING_OUT && calm_ff == 5'h1F && ctrl_ff[15:12] == 4'h0 |-> !FAULT_OUT && !CURRENT_LIMIT_OUT;
    endproperty
    a_state_mask: assert property (p_state_mask) else $error("state blanking leaked");
    // Assumes no retrigger and a delay below 16
    property p_leb_len;
        $fell(BLANKING_OUT) && calm_ff == 5'h1F && ctrl_ff[5:0] == 6'h00 && dly_ff < 12'h010 |-> run_ff == dly_ff[4:0];
    endproperty
    a_leb_len: assert property (p_leb_len) else $error("blanking length wrong");
    property p_flt_src; FAULT_OUT |-> flt_ff != 8'h00; endproperty
    a_flt_src: assert property (p_flt_src) else $error("fault without cause");
    c_leb: cover property ($fell(BLANKING_OUT) && run_ff == 5'h06);
    c_blank: cover property (BLANKING_OUT && FAULT_IN && !FAULT_OUT);
    c_unmapped: cover property (RD_IN && ADDR_IN > 4'h3);
endmodule
bind pwmleb_top pwmleb_checker #(.DELAY_W(DELAY_W), .NSRC(NSRC)) u_pwmleb_checker (.CLK_IN(CLK_IN),
    .RESET_N_IN(RESET_N_IN), .CLK_EN_IN(CLK_EN_IN), .ADDR_IN(ADDR_IN), .WDATA_IN(WDATA_IN), .WR_IN(WR_IN),
    .RD_IN(RD_IN), .HIGH_SIDE_OUTPUT_IN(HIGH_SIDE_OUTPUT_IN), .LOW_SIDE_OUTPUT_IN(LOW_SIDE_OUTPUT_IN),
    .BLANK_SRC_IN(BLANK_SRC_IN), .FAULT_IN(FAULT_IN), .CURRENT_LIMIT_IN(CURRENT_LIMIT_IN), .RDATA_OUT(RDATA_OUT),
    .FAULT_OUT(FAULT_OUT), .CURRENT_LIMIT_OUT(CURRENT_LIMIT_OUT), .BLANKING_OUT(BLANKING_OUT));

// *** verification/pwmleb_stage_model.sv ***
// Power stage and comparator model
`timescale 1ns/1ps
module pwmleb_stage_model (
    input wire logic clk_in, // Clock
    output logic hs_out, // High-side level
    output logic ls_out, // Low-side level
    output logic [3:0] src_out, // Blanking sources
    output logic flt_out, // Fault, active high
    output logic cl_out // Limit, active high
);
    // Quiet stage at start
    initial begin
        {src_out, ls_out, hs_out, flt_out, cl_out} = 8'h00;
    end
    // Levels move just after an edge and hold
    task automatic drive(input logic [7:0] lvl);
        @(posedge clk_in);
        {src_out, ls_out, hs_out, flt_out, cl_out} <= lvl;
    endtask
endmodule
